// ==== logic/smc_defines.vh ====
// constants for the switch mode controller and serial target
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
`define SMC_MODE_POWER_OFF 2'h0
`define SMC_MODE_SLEEP 2'h1
`define SMC_MODE_NORMAL 2'h2
`define SMC_MODE_FAIL 2'h3
`define SMC_FRAME_BITS 16
`define SMC_ADDR_MSB 15
`define SMC_ADDR_LSB 12
`define SMC_WD_BIT 11
`define SMC_DATA_MSB 10
`define SMC_ADDR_INIT1 4'h0
`define SMC_ADDR_CH1 4'h2
`define SMC_ADDR_OUTCTL 4'h8
`define SMC_CLK_MHZ 200
`define SMC_INIT_TIME_US 50
`define SMC_INIT_CYCLES (`SMC_INIT_TIME_US * `SMC_CLK_MHZ)
`define SMC_BLANK_TIME_US 50
`define SMC_BLANK_CYCLES (`SMC_BLANK_TIME_US * `SMC_CLK_MHZ)
`define SMC_WD_TIME_US 1000
`define SMC_WD_CYCLES (`SMC_WD_TIME_US * `SMC_CLK_MHZ)
`define SMC_STUCK_TIME_US 2000
`define SMC_STUCK_CYCLES (`SMC_STUCK_TIME_US * `SMC_CLK_MHZ)
`define SMC_SO_DSF_BIT 10
`define SMC_SO_RCF_BIT 9
`endif

// ==== logic/smc_mode_spi.v ====
// operating mode controller with 16-bit serial target
// Summary of operation
// - four modes: sleep, normal, fail, power off
// - wake is direct inputs or reset pin
// - fail is home input or serial failure
// - start in power off, then sleep, outputs off
// - normal: outputs follow serial settings
// - fail: channels 1-4 follow inputs, 5-6 off
// - fail: writes ignored, readback is select bits, flags, status word
// - fail: overload restarts, severe faults latch off
// - wake clears registers and blanks faults
// - init completes 50 us after reset pin rise
// - fail entry clears registers, keeps status
// - stuck line disables diagnosis in fail
// - two toggle frames 0 then 1 recover
// - recovery clears registers but not latch-offs, sets status flags
// - cleared flag stays until status read
// - 16-bit full duplex, daisy chainable
// - sample input on serial clock rise
// - output changes on serial clock rise
// - select fall loads, select rise latches
// - select high: ignore clock, output released
// - reset pin low holds registers reset, except in fail
// - top four bits are address
// - bit eleven is watchdog toggle
// - bits ten to zero are data
// - all registers reset to zero
`include "smc_defines.vh"
module smc_mode_spi #(
    parameter INIT_CYCLES = `SMC_INIT_CYCLES,
    parameter BLANK_CYCLES = `SMC_BLANK_CYCLES,
    parameter WD_CYCLES = `SMC_WD_CYCLES,
    parameter STUCK_CYCLES = `SMC_STUCK_CYCLES
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_supply_ok,
    input wire i_reset_wake_pin,
    input wire [3:0] i_direct_control_inputs,
    input wire i_home_input_a,
    input wire [5:0] i_pwm_drive,
    input wire [5:0] i_overload,
    input wire [5:0] i_severe_fault,
    input wire [10:0] i_status_word,
    input wire i_chip_select_n,
    input wire i_sclk,
    input wire i_sdi,
    output reg o_sdo,
    output reg o_sdo_oe,
    output reg [1:0] o_mode,
    output reg [4:0] o_power_channel_pins,
    output reg o_external_switch_drive,
    output reg o_init_done,
    output reg o_fault_blank,
    output reg o_diag_avail,
    output reg o_register_cleared_flag,
    output reg o_device_status_flag,
    output reg [3:0] o_readback_select_bits,
    output reg [5:0] o_channel_on,
    output reg [7:0] o_ch1_duty
);

// ***************************************************
// pin synchronisers
// ***************************************************
reg [2:0] cs_sync_reg, ck_sync_reg, di_sync_reg, rw_sync_reg, hm_sync_reg;
reg [2:0] in_sync_reg [0:3];
reg cs_reg, ck_reg, di_reg, rw_reg, hm_reg;
reg [3:0] in_reg;
reg [2:0] sp_sync_reg;
reg sp_reg;
integer k;

function stable_next;
    input [2:0] s;
    input cur;
    begin
        stable_next = (s[2] == s[1]) ? s[1] : cur;
    end
endfunction

always @(posedge i_clk) begin
    cs_sync_reg <= {cs_sync_reg[1:0], i_chip_select_n};
    ck_sync_reg <= {ck_sync_reg[1:0], i_sclk};
    di_sync_reg <= {di_sync_reg[1:0], i_sdi};
    rw_sync_reg <= {rw_sync_reg[1:0], i_reset_wake_pin};
    hm_sync_reg <= {hm_sync_reg[1:0], i_home_input_a};
    sp_sync_reg <= {sp_sync_reg[1:0], i_supply_ok};
    for (k = 0; k < 4; k = k + 1) begin
        in_sync_reg[k] <= {in_sync_reg[k][1:0], i_direct_control_inputs[k]};
    end
    if (i_rst) begin
        cs_reg <= 1'b1;
        ck_reg <= 1'b0;
        di_reg <= 1'b0;
        rw_reg <= 1'b0;
        hm_reg <= 1'b0;
        in_reg <= 4'h0;
        sp_reg <= 1'b1;
    end else begin
        cs_reg <= stable_next(cs_sync_reg, cs_reg);
        ck_reg <= stable_next(ck_sync_reg, ck_reg);
        di_reg <= stable_next(di_sync_reg, di_reg);
        rw_reg <= stable_next(rw_sync_reg, rw_reg);
        hm_reg <= stable_next(hm_sync_reg, hm_reg);
        sp_reg <= stable_next(sp_sync_reg, sp_reg);
        for (k = 0; k < 4; k = k + 1) begin
            in_reg[k] <= stable_next(in_sync_reg[k], in_reg[k]);
        end
    end
end

// ***************************************************
// mode conditions
// ***************************************************
reg ck_prev_reg, cs_prev_reg, rw_prev_reg;
wire sck_rise = ck_reg & ~ck_prev_reg & ~cs_reg;
wire cs_fall = cs_prev_reg & ~cs_reg;
wire cs_rise = ~cs_prev_reg & cs_reg;
wire wake = (|in_reg) | rw_reg;
reg spi_fail_reg, stuck_fail_reg;
wire fail = hm_reg | spi_fail_reg;
reg [1:0] mode_reg;
reg [1:0] mode_next;
wire wake_rise = (mode_reg == `SMC_MODE_SLEEP) & wake;
wire regs_hold = ~rw_reg & (mode_reg != `SMC_MODE_FAIL);

// ***************************************************
// mode selection
// ***************************************************
always @* begin
    mode_next = mode_reg;
    case (mode_reg)
        `SMC_MODE_POWER_OFF: mode_next = `SMC_MODE_SLEEP;
        `SMC_MODE_SLEEP: if (wake) mode_next = fail ? `SMC_MODE_FAIL : `SMC_MODE_NORMAL;
        `SMC_MODE_NORMAL: begin
            if (!wake) mode_next = `SMC_MODE_SLEEP;
            else if (fail) mode_next = `SMC_MODE_FAIL;
        end
        `SMC_MODE_FAIL: if (!wake) mode_next = `SMC_MODE_SLEEP;
        default: mode_next = `SMC_MODE_SLEEP;
    endcase
    if (!sp_reg) mode_next = `SMC_MODE_POWER_OFF;
end

// ***************************************************
// serial shift and latch
// ***************************************************
reg [15:0] rx_reg, tx_reg;
reg [4:0] bit_cnt_reg;
wire [4:0] bit_cnt_inc = {bit_cnt_reg[4] | (&bit_cnt_reg[3:0]), bit_cnt_reg[3:0] + 4'h1};
reg wd_last_reg, wd_seen0_reg;
reg [31:0] wd_cnt_reg, stuck_cnt_reg, init_cnt_reg, blank_cnt_reg;
reg [10:0] init1_reg, outctl_reg, ch1_reg;
reg [5:0] latch_off_reg;
wire frame_ok = (bit_cnt_reg[3:0] == 4'h0) & bit_cnt_reg[4];
wire [3:0] rx_addr = rx_reg[`SMC_ADDR_MSB:`SMC_ADDR_LSB];
wire rx_wd = rx_reg[`SMC_WD_BIT];
wire [10:0] rx_data = rx_reg[`SMC_DATA_MSB:0];
wire recover = (mode_reg == `SMC_MODE_FAIL) & ~hm_reg & cs_rise & frame_ok & wd_seen0_reg & rx_wd;
wire [15:0] status_frame = {o_readback_select_bits, o_device_status_flag, o_register_cleared_flag, i_status_word[9:0]};

always @(posedge i_clk) begin
    if (i_rst) begin
        ck_prev_reg <= 1'b0;
        cs_prev_reg <= 1'b1;
        rw_prev_reg <= 1'b0;
    end else begin
        ck_prev_reg <= ck_reg;
        cs_prev_reg <= cs_reg;
        rw_prev_reg <= rw_reg;
    end
    if (i_rst || mode_reg == `SMC_MODE_POWER_OFF || mode_reg == `SMC_MODE_SLEEP || wake_rise) begin
        mode_reg <= (i_rst) ? `SMC_MODE_POWER_OFF : mode_next;
        rx_reg <= 16'h0000;
        tx_reg <= 16'h0000;
        bit_cnt_reg <= 5'h00;
        init1_reg <= 11'h000;
        outctl_reg <= 11'h000;
        ch1_reg <= 11'h000;
        o_register_cleared_flag <= 1'b0;
        o_device_status_flag <= 1'b0;
        wd_last_reg <= 1'b0;
        wd_seen0_reg <= 1'b0;
        spi_fail_reg <= 1'b0;
        stuck_fail_reg <= 1'b0;
        wd_cnt_reg <= 32'h0;
        stuck_cnt_reg <= 32'h0;
        latch_off_reg <= 6'h00;
        blank_cnt_reg <= BLANK_CYCLES;
        init_cnt_reg <= INIT_CYCLES;
    end else begin
        mode_reg <= mode_next;
        if (blank_cnt_reg != 32'h0) blank_cnt_reg <= blank_cnt_reg - 32'h1;
        if (rw_reg & ~rw_prev_reg) init_cnt_reg <= INIT_CYCLES;
        else if (init_cnt_reg != 32'h0) init_cnt_reg <= init_cnt_reg - 32'h1;
        if (cs_fall) begin
            tx_reg <= status_frame;
            bit_cnt_reg <= 5'h00;
        end else if (sck_rise) begin
            rx_reg <= {rx_reg[14:0], di_reg};
            tx_reg <= {tx_reg[14:0], di_reg};
            bit_cnt_reg <= bit_cnt_inc;
        end
        if (cs_reg | sck_rise) stuck_cnt_reg <= 32'h0;
        else if (stuck_cnt_reg != STUCK_CYCLES) stuck_cnt_reg <= stuck_cnt_reg + 32'h1;
        if (wd_cnt_reg != WD_CYCLES) wd_cnt_reg <= wd_cnt_reg + 32'h1;
        if (mode_reg == `SMC_MODE_FAIL && wd_cnt_reg == WD_CYCLES) wd_seen0_reg <= 1'b0;
        if (mode_reg == `SMC_MODE_NORMAL && mode_next == `SMC_MODE_FAIL) begin
            init1_reg <= 11'h000;
            outctl_reg <= 11'h000;
            ch1_reg <= 11'h000;
        end else if (recover) begin
            mode_reg <= `SMC_MODE_NORMAL;
            init1_reg <= 11'h000;
            outctl_reg <= 11'h000;
            ch1_reg <= 11'h000;
            tx_reg <= 16'h0000;
            spi_fail_reg <= 1'b0;
            stuck_fail_reg <= 1'b0;
            wd_cnt_reg <= 32'h0;
            wd_seen0_reg <= 1'b0;
            o_device_status_flag <= 1'b1;
            o_register_cleared_flag <= 1'b1;
        end else if (cs_rise) begin
            if (!frame_ok && bit_cnt_reg != 5'h00) spi_fail_reg <= 1'b1;
            else if (frame_ok) begin
                if (mode_reg == `SMC_MODE_NORMAL) begin
                    if (rx_wd != wd_last_reg) wd_cnt_reg <= 32'h0;
                    wd_last_reg <= rx_wd;
                    case (rx_addr)
                        `SMC_ADDR_INIT1: init1_reg <= rx_data;
                        `SMC_ADDR_CH1: ch1_reg <= rx_data;
                        `SMC_ADDR_OUTCTL: outctl_reg <= rx_data;
                        default: ;
                    endcase
                    if (rx_addr == `SMC_ADDR_INIT1 && rx_data[3:0] == 4'h1) o_register_cleared_flag <= 1'b0;
                end else begin
                    wd_seen0_reg <= ~rx_wd;
                    if (!rx_wd) wd_cnt_reg <= 32'h0;
                    wd_last_reg <= rx_wd;
                end
            end
        end
        if (mode_reg == `SMC_MODE_NORMAL && wd_cnt_reg == WD_CYCLES) spi_fail_reg <= 1'b1;
        if (stuck_cnt_reg == STUCK_CYCLES) begin
            spi_fail_reg <= 1'b1;
            stuck_fail_reg <= 1'b1;
        end
        if (mode_reg == `SMC_MODE_FAIL && blank_cnt_reg == 32'h0) latch_off_reg <= latch_off_reg | i_severe_fault;
        if (regs_hold) begin
            init1_reg <= 11'h000;
            outctl_reg <= 11'h000;
            ch1_reg <= 11'h000;
        end
    end
end

// ***************************************************
// outputs
// ***************************************************
always @(posedge i_clk) begin
    if (i_rst) begin
        o_sdo <= 1'b0;
        o_sdo_oe <= 1'b0;
        o_mode <= `SMC_MODE_POWER_OFF;
        o_power_channel_pins <= 5'h00;
        o_external_switch_drive <= 1'b0;
        o_init_done <= 1'b0;
        o_fault_blank <= 1'b0;
        o_diag_avail <= 1'b0;
        o_readback_select_bits <= 4'h0;
        o_channel_on <= 6'h00;
        o_ch1_duty <= 8'h00;
    end else begin
        if (cs_fall) o_sdo <= status_frame[15];
        else if (sck_rise) o_sdo <= tx_reg[15];
        o_sdo_oe <= ~cs_reg & o_diag_avail;
        o_mode <= mode_reg;
        o_init_done <= (mode_reg == `SMC_MODE_NORMAL) & (init_cnt_reg == 32'h0);
        o_fault_blank <= blank_cnt_reg != 32'h0;
        o_diag_avail <= (mode_reg == `SMC_MODE_NORMAL) | ((mode_reg == `SMC_MODE_FAIL) & ~stuck_fail_reg);
        o_readback_select_bits <= init1_reg[3:0];
        o_channel_on <= outctl_reg[5:0];
        o_ch1_duty <= ch1_reg[7:0];
        case (mode_reg)
            `SMC_MODE_NORMAL: begin
                o_power_channel_pins <= i_pwm_drive[4:0] & outctl_reg[4:0];
                o_external_switch_drive <= i_pwm_drive[5] & outctl_reg[5];
            end
            `SMC_MODE_FAIL: begin
                o_power_channel_pins <= {1'b0, in_reg & ~i_overload[3:0] & ~latch_off_reg[3:0]};
                o_external_switch_drive <= 1'b0;
            end
            default: begin
                o_power_channel_pins <= 5'h00;
                o_external_switch_drive <= 1'b0;
            end
        endcase
    end
end

endmodule

// ==== test/smc_mode_spi_assertions.sv ====
// checker for mode and serial target outputs
module smc_mode_spi_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_select_n,
    input wire logic o_sdo_oe,
    input wire logic [1:0] o_mode,
    input wire logic [4:0] o_power_channel_pins,
    input wire logic o_external_switch_drive,
    input wire logic o_register_cleared_flag,
    input wire logic o_device_status_flag,
    input wire logic [5:0] o_channel_on,
    input wire logic [7:0] o_ch1_duty
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_reset_clear; $fell(i_rst) |-> o_mode == 2'h0 && o_channel_on == 6'h0 && o_ch1_duty == 8'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
    property p_off_quiet; o_mode == 2'h0 |-> o_power_channel_pins == 5'h0 && !o_external_switch_drive;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("output on in power off");
    property p_sleep_quiet; o_mode == 2'h1 |-> o_power_channel_pins == 5'h0 && !o_external_switch_drive;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("output on in sleep");
    property p_fail_off; o_mode == 2'h3 |-> !o_external_switch_drive && !o_power_channel_pins[4];
    endproperty
    a_fail_off: assert property (p_fail_off) else $error("channel five or six on in fail");
    property p_fail_hold; o_mode == 2'h3 && $past(o_mode) == 2'h3 |-> $stable(o_ch1_duty) && $stable(o_channel_on);
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("setting changed in fail");
    property p_fail_clear; o_mode == 2'h3 && $past(o_mode) == 2'h2 |-> ##[0:2] o_channel_on == 6'h0 && o_ch1_duty == 8'h0;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("settings kept on fail entry");
    property p_cs_release; i_chip_select_n [*8] |-> !o_sdo_oe;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("serial out driven while deselected");
    property p_recover_flags; o_mode == 2'h2 && $past(o_mode) == 2'h3 |-> ##[0:2] o_register_cleared_flag
        && o_device_status_flag && o_channel_on == 6'h0;
    endproperty
    a_recover_flags: assert property (p_recover_flags) else $error("flags not set on recovery");
endmodule
bind smc_mode_spi smc_mode_spi_assertions smc_mode_spi_assertions_i (.i_clk, .i_rst, .i_chip_select_n, .o_sdo_oe,
    .o_mode, .o_power_channel_pins, .o_external_switch_drive, .o_register_cleared_flag, .o_device_status_flag,
    .o_channel_on, .o_ch1_duty);

// ==== test/smc_host_model.sv ====
// host controller model on the serial pins
module smc_host_model (
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_chip_select_n,
    output logic o_sclk,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_chip_select_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] rx);
        rx = 16'h0;
        o_chip_select_n = 1'b0;
        repeat (13) @(negedge i_clk);
        for (int k = 0; k < nbits; k++) begin
            o_sdi = word[15 - k];
            repeat (12) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (13) @(negedge i_clk);
            o_sclk = 1'b0;
            rx = {rx[14:0], i_sdo_oe ? i_sdo : 1'bx};
        end
        repeat (12) @(negedge i_clk);
        o_chip_select_n = 1'b1;
        o_sdi = ~o_sdi;
        repeat (25) @(negedge i_clk);
    endtask
endmodule

// ==== test/smc_mode_spi_tb.sv ====
// self-checking bench for the mode controller
`include "smc_defines.vh"
module smc_mode_spi_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst, i_supply_ok, i_reset_wake_pin, i_home_input_a, i_chip_select_n, i_sclk, i_sdi, o_sdo;
    logic o_sdo_oe, o_external_switch_drive, o_init_done, o_fault_blank, o_diag_avail, wd;
    logic o_register_cleared_flag, o_device_status_flag;
    logic [1:0] o_mode;
    logic [3:0] i_direct_control_inputs, o_readback_select_bits;
    logic [4:0] o_power_channel_pins;
    logic [5:0] o_channel_on;
    logic [7:0] o_ch1_duty;
    logic [5:0] i_pwm_drive, i_overload, i_severe_fault;
    logic [10:0] i_status_word;
    logic [15:0] rx;
    int fail_count = 0;
    int samples_checked = 0;
    smc_mode_spi #(.INIT_CYCLES(100), .BLANK_CYCLES(100), .WD_CYCLES(20000), .STUCK_CYCLES(50000))
        smc_mode_spi_i (.i_clk, .i_rst, .i_supply_ok, .i_reset_wake_pin, .i_direct_control_inputs, .i_home_input_a,
        .i_pwm_drive, .i_overload, .i_severe_fault, .i_status_word,
        .i_chip_select_n, .i_sclk, .i_sdi, .o_sdo, .o_sdo_oe, .o_mode, .o_power_channel_pins,
        .o_external_switch_drive, .o_init_done, .o_fault_blank, .o_diag_avail, .o_register_cleared_flag,
        .o_device_status_flag, .o_readback_select_bits, .o_channel_on, .o_ch1_duty);
    smc_host_model smc_host_model_i (.i_clk, .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe),
        .o_chip_select_n(i_chip_select_n), .o_sclk(i_sclk), .o_sdi(i_sdi));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int n = 0; n < 2000 && o_mode !== m; n++) @(negedge i_clk);
        check({14'h0, o_mode}, {14'h0, m});
    endtask
    task automatic send(input logic [3:0] a, input logic [10:0] d, input int n);
        smc_host_model_i.frame({a, wd, d}, n, rx);
        wd = ~wd;
        repeat (10) @(negedge i_clk);
    endtask
    task automatic t_wake();
        wait_mode(`SMC_MODE_SLEEP);
        i_reset_wake_pin = 1'b1;
        wait_mode(`SMC_MODE_NORMAL);
        check({14'h0, o_fault_blank, o_init_done}, 16'h2);
        repeat (110) @(negedge i_clk);
        check({14'h0, o_fault_blank, o_init_done}, 16'h1);
    endtask
    task automatic t_write();
        send(`SMC_ADDR_OUTCTL, 11'h03f, 16);
        check(rx, 16'h02a5);
        check({10'h0, o_channel_on}, 16'h3f);
        i_pwm_drive = 6'h2b;
        repeat (2) @(negedge i_clk);
        check({10'h0, o_external_switch_drive, o_power_channel_pins}, 16'h2b);
        send(`SMC_ADDR_INIT1, 11'h002, 16);
        send(`SMC_ADDR_CH1, 11'h05a, 16);
        check(rx, 16'h22a5);
        check({8'h0, o_ch1_duty}, 16'h5a);
        check({12'h0, o_readback_select_bits}, 16'h2);
    endtask
    task automatic t_fail_len();
        i_direct_control_inputs = 4'h5;
        send(`SMC_ADDR_OUTCTL, 11'h03f, 15);
        wait_mode(`SMC_MODE_FAIL);
        check({10'h0, o_channel_on}, 16'h0);
        check({15'h0, o_diag_avail}, 16'h1);
        repeat (10) @(negedge i_clk);
        check({11'h0, o_power_channel_pins}, 16'h5);
        i_overload = 6'h01;
        repeat (2) @(negedge i_clk);
        check({11'h0, o_power_channel_pins}, 16'h4);
        i_overload = 6'h00;
        i_severe_fault = 6'h04;
        repeat (2) @(negedge i_clk);
        i_severe_fault = 6'h00;
        repeat (2) @(negedge i_clk);
        check({11'h0, o_power_channel_pins}, 16'h1);
        send(`SMC_ADDR_CH1, 11'h0ff, 16);
        check({8'h0, o_ch1_duty}, 16'h0);
    endtask
    task automatic t_recover();
        wd = 1'b0;
        send(`SMC_ADDR_INIT1, 11'h000, 16);
        send(`SMC_ADDR_INIT1, 11'h000, 16);
        wait_mode(`SMC_MODE_NORMAL);
        check({14'h0, o_device_status_flag, o_register_cleared_flag}, 16'h3);
        send(`SMC_ADDR_INIT1, 11'h001, 16);
        check(rx & 16'h0600, 16'h0600);
        check({15'h0, o_register_cleared_flag}, 16'h0);
    endtask
    task automatic t_home();
        i_home_input_a = 1'b1;
        wait_mode(`SMC_MODE_FAIL);
        check({15'h0, o_diag_avail}, 16'h1);
        i_home_input_a = 1'b0;
        t_recover();
    endtask
    task automatic t_sleep_off();
        send(`SMC_ADDR_OUTCTL, 11'h03f, 16);
        check({10'h0, o_channel_on}, 16'h3f);
        i_reset_wake_pin = 1'b0;
        repeat (10) @(negedge i_clk);
        check({8'h0, o_channel_on, o_mode}, 16'h2);
        i_direct_control_inputs = 4'h0;
        wait_mode(`SMC_MODE_SLEEP);
        check({10'h0, o_channel_on}, 16'h0);
        i_supply_ok = 1'b0;
        wait_mode(`SMC_MODE_POWER_OFF);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {i_rst, i_supply_ok, i_reset_wake_pin, i_home_input_a, wd} = 5'h18;
        i_direct_control_inputs = 4'h0;
        {i_pwm_drive, i_overload, i_severe_fault} = 18'h0;
        i_status_word = 11'h2a5;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        t_wake();
        t_write();
        t_fail_len();
        t_recover();
        t_home();
        t_sleep_off();
        report_and_stop();
    end
endmodule
